// >>> logic/dcc_pkg.sv
/*
 Package for the DMA channel configuration and control block: register
 offsets, field positions, reset values, carrier structs and the
 flow-control decode.
 Assumes one clock domain and a single-cycle register port.
*/
// Function
// - Halt ignores new source requests, FIFO drains
// - Active bit reads 1 while FIFO holds data
// - Lock bit makes channel transfers locked
// - Terminal-count mask zero suppresses tc interrupt
// - Error mask zero suppresses error interrupt
// - Flow codes 000-011 give controller-owned types
// - Flow codes 100-111 give peripheral-owned flow
// - Destination select ignored when destination is memory
// - Source select ignored when source is memory
// - Select fields are binary line indices
// - Enable bit starts channel, reads enable state
// - Clearing enable finishes transfer, FIFO discarded
// - Last item or error clears enable itself
// - Reserved bits read undefined, written zero
// - Enable state mirrored in enabled-channels status
// - Linked item fetch never changes configuration
package dcc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam int DCC_AW = 8;
    localparam logic [7:0] DCC_OFS_CFG = 8'h00;
    localparam logic [7:0] DCC_OFS_ENSTS = 8'h04;
    localparam logic [7:0] DCC_OFS_ISTS = 8'h08;
    localparam logic [7:0] DCC_OFS_IMSK = 8'h0c;

    // Configuration field positions
    localparam int DCC_B_EN = 0;
    localparam int DCC_B_SRC = 1;
    localparam int DCC_B_DST = 6;
    localparam int DCC_B_FLOW = 11;
    localparam int DCC_B_ERRM = 14;
    localparam int DCC_B_TCM = 15;
    localparam int DCC_B_LOCK = 16;
    localparam int DCC_B_ACT = 17;
    localparam int DCC_B_HALT = 18;

    // Interrupt status and mask bit positions
    localparam int DCC_I_TC = 0;
    localparam int DCC_I_ERR = 1;
    localparam int DCC_I_OFF = 2;
    localparam int DCC_IRQ_W = 3;
    localparam logic [2:0] DCC_IMSK_RST = 3'h0;

    // Request lines and channel FIFO size in words
    localparam int DCC_NREQ = 16;
    localparam int DCC_FIFO_DEPTH = 4;
    localparam int DCC_FIFO_CW = 3;
    localparam logic [2:0] DCC_FIFO_FULL = 3'h4;

    ////////////////////////////////////////////////////////////////////
    // Software-written configuration fields
    typedef struct packed {
        logic halt;
        logic lock;
        logic tc_irq_mask;
        logic err_irq_mask;
        logic [2:0] flow_owner_and_xfer_type;
        logic [3:0] dst_request_select;
        logic [3:0] src_request_select;
    } dcc_cfg_t;
    localparam dcc_cfg_t DCC_CFG_RST = '0;

    // Who paces the transfer
    typedef enum logic [1:0] {
        DCC_OWN_DMA,
        DCC_OWN_DST,
        DCC_OWN_SRC,
        DCC_OWN_PERIPH
    } dcc_owner_t;

    // Decoded transfer type
    typedef struct packed {
        logic src_periph;
        logic dst_periph;
        dcc_owner_t owner;
    } dcc_xfer_t;

    // Channel enable life cycle
    typedef enum logic [1:0] {
        DCC_ST_IDLE,
        DCC_ST_RUN,
        DCC_ST_STOP
    } dcc_state_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dcc_reg_req_t;

    // Events from the transfer engine, same clock
    typedef struct packed {
        logic bus_busy;
        logic fill;
        logic drain;
        logic last_item_done;
        logic chan_error;
        logic tc_event;
    } dcc_eng_evt_t;

    ////////////////////////////////////////////////////////////////////
    // Flow-control code to transfer type and owner
    function automatic dcc_xfer_t dcc_decode_flow(input logic [2:0] code);
        dcc_xfer_t x;
        x = '{src_periph: 1'b0, dst_periph: 1'b0, owner: DCC_OWN_DMA};
        case (code)
            3'h0: x = '{1'b0, 1'b0, DCC_OWN_DMA};
            3'h1: x = '{1'b0, 1'b1, DCC_OWN_DMA};
            3'h2: x = '{1'b1, 1'b0, DCC_OWN_DMA};
            3'h3: x = '{1'b1, 1'b1, DCC_OWN_DMA};
            3'h4: x = '{1'b1, 1'b1, DCC_OWN_DST};
            3'h5: x = '{1'b0, 1'b1, DCC_OWN_PERIPH};
            3'h6: x = '{1'b1, 1'b0, DCC_OWN_PERIPH};
            default: x = '{1'b1, 1'b1, DCC_OWN_SRC};
        endcase
        return x;
    endfunction

endpackage

// >>> logic/dcc_req_sync.sv
/*
 Synchroniser for the peripheral DMA request pins.
 Assumes the pins are asynchronous to clk_sys; a level change is taken
 once the second and third stages agree.
*/
module dcc_req_sync (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    // Raw request pins
    input wire logic [dcc_pkg::DCC_NREQ-1:0] req_pin,
    // Filtered request levels
    output logic [dcc_pkg::DCC_NREQ-1:0] req_level
);
    import dcc_pkg::*;

    // Three stages plus the accepted level
    typedef struct packed {
        logic [DCC_NREQ-1:0] s1;
        logic [DCC_NREQ-1:0] s2;
        logic [DCC_NREQ-1:0] s3;
        logic [DCC_NREQ-1:0] lvl;
    } dcc_sync_st_t;

    dcc_sync_st_t cur;
    dcc_sync_st_t next_st;

    ////////////////////////////////////////////////////////////////////
    // Shift and accept agreeing bits; s1 feeds only s2
    always_comb begin
        next_st = cur;
        next_st.s1 = req_pin;
        next_st.s2 = cur.s1;
        next_st.s3 = cur.s2;
        for (int i = 0; i < DCC_NREQ; i++) begin
            if (cur.s2[i] == cur.s3[i]) begin
                next_st.lvl[i] = cur.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_st;
        end
    end

    assign req_level = cur.lvl;

endmodule

// >>> logic/dcc_fifo_level.sv
/*
 Occupancy tracker for the channel FIFO.
 Assumes the engine pulses fill and drain once per word; flush empties it.
*/
module dcc_fifo_level (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    // Word movement
    input wire logic fill,
    input wire logic drain,
    input wire logic flush,
    // Status
    output logic active,
    output logic full
);
    import dcc_pkg::*;

    // Word count
    typedef struct packed {
        logic [DCC_FIFO_CW-1:0] count;
    } dcc_lvl_st_t;

    dcc_lvl_st_t cur;
    dcc_lvl_st_t next_st;
    logic do_fill;
    logic do_drain;

    ////////////////////////////////////////////////////////////////////
    // Refuse fill when full, drain when empty; flush wins
    always_comb begin
        next_st = cur;
        do_fill = fill && (cur.count != DCC_FIFO_FULL);
        do_drain = drain && (cur.count != '0);
        if (flush) begin
            next_st.count = '0;
        end else if (do_fill && !do_drain) begin
            next_st.count = cur.count + 3'h1;
        end else if (do_drain && !do_fill) begin
            next_st.count = cur.count - 3'h1;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_st;
        end
    end

    assign active = (cur.count != '0);
    assign full = (cur.count == DCC_FIFO_FULL);

endmodule

// >>> logic/dcc_channel.sv
/*
 Configuration and control of one DMA channel: the configuration
 register, enable life cycle, request-line selection, lock, interrupt
 masking and the enabled-channels mirror.
 Assumes a transfer engine on clk_sys that reports bus activity and FIFO
 word movement, and peripheral request pins from outside the domain.
*/
module dcc_channel (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    // Register port
    input wire dcc_pkg::dcc_reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    // Peripheral request pins
    input wire logic [dcc_pkg::DCC_NREQ-1:0] dma_req_pin,
    // Transfer engine events
    input wire dcc_pkg::dcc_eng_evt_t eng_evt,
    // Transfer control to the engine
    output logic src_req_grant,
    output logic dst_req_level,
    output logic bus_lock,
    output dcc_pkg::dcc_xfer_t xfer,
    output logic chan_enabled,
    output logic drain_only,
    output logic fifo_flush,
    output logic fifo_active,
    output logic fifo_full,
    // Interrupts
    output logic tc_irq,
    output logic err_irq,
    output logic irq
);
    import dcc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        dcc_cfg_t cfg;
        dcc_state_t st;
        logic [DCC_IRQ_W-1:0] ists;
        logic [DCC_IRQ_W-1:0] imsk;
        logic flush;
        logic [31:0] rdata;
    } dcc_chan_st_t;

    dcc_chan_st_t cur; // Registered state
    dcc_chan_st_t next_st; // Next state
    logic [DCC_NREQ-1:0] req_level; // Synchronised requests
    logic wr_cfg; // Config write this cycle
    logic wr_ists; // Status clear write
    logic wr_imsk; // Mask write
    logic running; // Channel may start new work
    logic go_idle; // Channel turns off this cycle
    logic src_line; // Selected source request
    logic dst_line; // Selected destination request
    logic [DCC_IRQ_W-1:0] ev_set; // Interrupt events
    logic [DCC_IRQ_W-1:0] gate; // Per-bit config gating

    ////////////////////////////////////////////////////////////////////
    // Pick one request line by its binary index
    function automatic logic pick_line(
        input logic [DCC_NREQ-1:0] lines,
        input logic [3:0] idx
    );
        return lines[idx];
    endfunction

    // Build the configuration word as software reads it
    function automatic logic [31:0] cfg_word(
        input dcc_cfg_t c,
        input logic en,
        input logic act
    );
        logic [31:0] w;
        w = '0;
        w[DCC_B_EN] = en;
        w[DCC_B_SRC +: 4] = c.src_request_select;
        w[DCC_B_DST +: 4] = c.dst_request_select;
        w[DCC_B_FLOW +: 3] = c.flow_owner_and_xfer_type;
        w[DCC_B_ERRM] = c.err_irq_mask;
        w[DCC_B_TCM] = c.tc_irq_mask;
        w[DCC_B_LOCK] = c.lock;
        w[DCC_B_ACT] = act;
        w[DCC_B_HALT] = c.halt;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Request pin synchroniser
    dcc_req_sync u_req_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ce(ce),
        .req_pin(dma_req_pin),
        .req_level(req_level)
    );

    // Channel FIFO occupancy
    dcc_fifo_level u_fifo_level (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ce(ce),
        .fill(eng_evt.fill),
        .drain(eng_evt.drain),
        .flush(cur.flush),
        .active(fifo_active),
        .full(fifo_full)
    );

    ////////////////////////////////////////////////////////////////////
    // Transfer type and request selection
    always_comb begin
        xfer = dcc_decode_flow(cur.cfg.flow_owner_and_xfer_type);
        running = (cur.st == DCC_ST_RUN);
        // Memory side leaves the select field unused
        src_line = xfer.src_periph
            && pick_line(req_level, cur.cfg.src_request_select);
        dst_line = xfer.dst_periph
            && pick_line(req_level, cur.cfg.dst_request_select);
    end

    // New source words only while running, not halted, with room
    assign src_req_grant = running && !cur.cfg.halt
        && src_line && !fifo_full;
    // Destination keeps draining while halted
    assign dst_req_level = running && dst_line;
    assign drain_only = cur.cfg.halt;
    assign bus_lock = cur.cfg.lock && (cur.st != DCC_ST_IDLE);
    assign chan_enabled = (cur.st != DCC_ST_IDLE);

    ////////////////////////////////////////////////////////////////////
    // Register decode
    always_comb begin
        wr_cfg = 1'b0;
        wr_ists = 1'b0;
        wr_imsk = 1'b0;
        if (reg_req.wr && reg_req.addr == DCC_OFS_CFG) begin
            wr_cfg = 1'b1;
        end else if (reg_req.wr && reg_req.addr == DCC_OFS_ISTS) begin
            wr_ists = 1'b1;
        end else if (reg_req.wr && reg_req.addr == DCC_OFS_IMSK) begin
            wr_imsk = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = cur;
        next_st.rdata = '0;
        next_st.flush = 1'b0;
        go_idle = 1'b0;

        // Read data stand one cycle after the strobe
        if (reg_req.rd) begin
            if (reg_req.addr == DCC_OFS_CFG) begin
                next_st.rdata = cfg_word(cur.cfg, chan_enabled, fifo_active);
            end else if (reg_req.addr == DCC_OFS_ENSTS) begin
                next_st.rdata = {31'h0, chan_enabled};
            end else if (reg_req.addr == DCC_OFS_ISTS) begin
                next_st.rdata = {29'h0, cur.ists};
            end else if (reg_req.addr == DCC_OFS_IMSK) begin
                next_st.rdata = {29'h0, cur.imsk};
            end
        end

        // Only software writes touch the configuration
        if (wr_cfg) begin
            next_st.cfg.halt = reg_req.wdata[DCC_B_HALT];
            next_st.cfg.lock = reg_req.wdata[DCC_B_LOCK];
            next_st.cfg.tc_irq_mask = reg_req.wdata[DCC_B_TCM];
            next_st.cfg.err_irq_mask = reg_req.wdata[DCC_B_ERRM];
            next_st.cfg.flow_owner_and_xfer_type =
                reg_req.wdata[DCC_B_FLOW +: 3];
            next_st.cfg.dst_request_select = reg_req.wdata[DCC_B_DST +: 4];
            next_st.cfg.src_request_select = reg_req.wdata[DCC_B_SRC +: 4];
        end

        // Enable life cycle
        case (cur.st)
            DCC_ST_IDLE: begin
                // Setting enable starts the channel
                if (wr_cfg && reg_req.wdata[DCC_B_EN]) begin
                    next_st.st = DCC_ST_RUN;
                end
            end
            DCC_ST_RUN: begin
                if (eng_evt.last_item_done || eng_evt.chan_error) begin
                    // Self-disable clears the enable bit
                    go_idle = 1'b1;
                end else if (wr_cfg && !reg_req.wdata[DCC_B_EN]) begin
                    // Let a running bus transfer finish first
                    if (eng_evt.bus_busy) begin
                        next_st.st = DCC_ST_STOP;
                    end else begin
                        go_idle = 1'b1;
                    end
                end
            end
            DCC_ST_STOP: begin
                // Off once the bus transfer ends, or on error
                if (!eng_evt.bus_busy || eng_evt.chan_error) begin
                    go_idle = 1'b1;
                end
            end
            default: begin
                next_st.st = DCC_ST_IDLE;
            end
        endcase

        // Turning off discards what the FIFO still holds
        if (go_idle) begin
            next_st.st = DCC_ST_IDLE;
            next_st.flush = 1'b1;
        end

        // Interrupt events
        ev_set = '0;
        ev_set[DCC_I_TC] = eng_evt.tc_event && (cur.st != DCC_ST_IDLE);
        ev_set[DCC_I_ERR] = eng_evt.chan_error && (cur.st != DCC_ST_IDLE);
        ev_set[DCC_I_OFF] = go_idle;

        // Write one clears; a same-cycle event wins
        if (wr_ists) begin
            next_st.ists = cur.ists & ~reg_req.wdata[DCC_IRQ_W-1:0];
        end
        next_st.ists = next_st.ists | ev_set;

        // Interrupt mask register
        if (wr_imsk) begin
            next_st.imsk = reg_req.wdata[DCC_IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cur.cfg <= DCC_CFG_RST;
            cur.st <= DCC_ST_IDLE;
            cur.ists <= '0;
            cur.imsk <= DCC_IMSK_RST;
            cur.flush <= 1'b0;
            cur.rdata <= '0;
        end else if (ce) begin
            cur <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = cur.rdata;
    assign fifo_flush = cur.flush;

    // Config masks gate terminal-count and error sources
    always_comb begin
        gate = '1;
        gate[DCC_I_TC] = cur.cfg.tc_irq_mask;
        gate[DCC_I_ERR] = cur.cfg.err_irq_mask;
    end

    assign tc_irq = cur.ists[DCC_I_TC] && cur.cfg.tc_irq_mask;
    assign err_irq = cur.ists[DCC_I_ERR] && cur.cfg.err_irq_mask;
    assign irq = |(cur.ists & cur.imsk & gate);

endmodule

// >>> testbench/dcc_chk.sv
/*
 Port checker of dcc_channel.
 Assumes one clock; bound into dcc_channel.
*/
module dcc_chk
    import dcc_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    // Register port
    input wire dcc_pkg::dcc_reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    // Engine side
    input wire dcc_pkg::dcc_eng_evt_t eng_evt,
    input wire logic src_req_grant,
    input wire logic dst_req_level,
    input wire logic bus_lock,
    input wire dcc_pkg::dcc_xfer_t xfer,
    input wire logic chan_enabled,
    input wire logic drain_only,
    input wire logic fifo_flush,
    input wire logic fifo_active,
    // Interrupts
    input wire logic tc_irq,
    input wire logic err_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////
    logic [1:0] msk; // Shadowed tc and error masks
    logic cfg_wr; // Config write taken
    assign cfg_wr = ce && reg_req.wr && reg_req.addr == DCC_OFS_CFG;
    // Follow software writes of the masks
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            msk <= 2'h0;
        end else if (cfg_wr) begin
            msk <= reg_req.wdata[15:14];
        end
    end
    ////////////////////////////////////////////////////////////////////
    sequence s_en_on; cfg_wr && reg_req.wdata[0] && !chan_enabled; endsequence
    sequence s_en_off; cfg_wr && !reg_req.wdata[0] && chan_enabled; endsequence
    sequence s_rd(a); ce && reg_req.rd && reg_req.addr == a; endsequence
    property p_halt; drain_only |-> !src_req_grant; endproperty
    property p_active; $rose(fifo_active) |-> $past(eng_evt.fill); endproperty
    property p_lock; bus_lock |-> chan_enabled; endproperty
    property p_tcm; !msk[1] |-> !tc_irq; endproperty
    property p_errm; !msk[0] |-> !err_irq; endproperty
    property p_srcmem; !xfer.src_periph |-> !src_req_grant; endproperty
    property p_dstmem; !xfer.dst_periph |-> !dst_req_level; endproperty
    property p_en; s_en_on |=> chan_enabled; endproperty
    property p_stop;
        s_en_off ##0 (eng_evt.bus_busy && !eng_evt.chan_error && !eng_evt.last_item_done)
            |=> chan_enabled;
    endproperty
    property p_off; s_en_off ##0 !eng_evt.bus_busy |=> !chan_enabled ##[0:1] fifo_flush;
    endproperty
    property p_err; chan_enabled && ce && eng_evt.chan_error |=> !chan_enabled; endproperty
    property p_read;
        s_rd(DCC_OFS_CFG) |=> reg_rdata[0] == $past(chan_enabled)
            && reg_rdata[17] == $past(fifo_active) && reg_rdata[31:19] == 13'h0;
    endproperty
    property p_mirror; s_rd(DCC_OFS_ENSTS) |=> reg_rdata[0] == $past(chan_enabled);
    endproperty
    a_halt: assert property (p_halt) else $error("grant while halted");
    a_active: assert property (p_active) else $error("active without fill");
    a_lock: assert property (p_lock) else $error("lock while off");
    a_tcm: assert property (p_tcm) else $error("tc irq masked");
    a_errm: assert property (p_errm) else $error("err irq masked");
    a_srcmem: assert property (p_srcmem) else $error("grant from memory");
    a_dstmem: assert property (p_dstmem) else $error("dst to memory");
    a_en: assert property (p_en) else $error("no enable");
    a_stop: assert property (p_stop) else $error("off during transfer");
    a_off: assert property (p_off) else $error("no off or flush");
    a_err: assert property (p_err) else $error("error kept on");
    a_read: assert property (p_read) else $error("config read wrong");
    a_mirror: assert property (p_mirror) else $error("mirror wrong");
endmodule
bind dcc_channel dcc_chk i_dcc_chk (.clk_sys, .reset_n, .ce, .reg_req, .reg_rdata,
    .eng_evt, .src_req_grant, .dst_req_level, .bus_lock, .xfer, .chan_enabled,
    .drain_only, .fifo_flush, .fifo_active, .tc_irq, .err_irq);

// >>> testbench/dcc_eng_model.sv
/*
 Engine model: FIFO word strobes and bench events.
 Assumes stall bits from the bench (0 fill, 1 drain).
*/
module dcc_eng_model
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Channel side
    input wire logic src_req_grant,
    input wire logic fifo_active,
    // Bench control
    input wire logic [1:0] stall,
    input wire dcc_pkg::dcc_eng_evt_t ctl,
    output dcc_pkg::dcc_eng_evt_t eng_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic fill; // Word fetched from source
    logic drain; // Word written to destination
    // Word strobes, paced by stall bits
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fill <= 1'b0;
            drain <= 1'b0;
        end else begin
            fill <= src_req_grant && !stall[0];
            drain <= fifo_active && !stall[1];
        end
    end
    // Bench events plus word strobes
    always_comb begin
        eng_evt = ctl;
        eng_evt.fill = fill;
        eng_evt.drain = drain;
    end
endmodule

// >>> testbench/tb.sv
/*
 Bench of dcc_channel.
 Assumes 20 MHz clk_sys.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dcc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    dcc_reg_req_t reg_req = '0;
    logic [15:0] dma_req_pin = '0;
    dcc_eng_evt_t ctl = '0;
    dcc_eng_evt_t eng_evt;
    dcc_xfer_t xfer;
    logic [1:0] stall = 2'h3;
    logic [1:0] mode = 2'h3; // Forced stalls, ORed with random ones
    logic [31:0] reg_rdata, d, v;
    logic [3:0] s;
    logic src_req_grant, dst_req_level, bus_lock, chan_enabled, drain_only;
    logic fifo_flush, fifo_active, fifo_full, tc_irq, err_irq, irq;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    always #25 clk_sys = ~clk_sys;
    dcc_channel i_dcc_channel (.clk_sys, .reset_n, .ce, .reg_req, .reg_rdata, .dma_req_pin,
        .eng_evt, .src_req_grant, .dst_req_level, .bus_lock, .xfer, .chan_enabled,
        .drain_only, .fifo_flush, .fifo_active, .fifo_full, .tc_irq, .err_irq, .irq);
    dcc_eng_model i_dcc_eng_model (.clk_sys, .reset_n, .src_req_grant, .fifo_active,
        .stall, .ctl, .eng_evt);
    ////////////////////////////////////////////////////////////////////
    // Random engine pacing and the hang limit
    always @(posedge clk_sys) begin
        stall <= mode | 2'($urandom);
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Register write; ends settled
    task automatic wr(logic [7:0] a, logic [31:0] val);
        @(posedge clk_sys);
        reg_req <= '{a, val, 1'b1, 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk_sys);
        reg_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic go(logic [31:0] val);
        wr(DCC_OFS_CFG, val & ~32'h1);
        wr(DCC_OFS_CFG, val);
    endtask
    // Pins, then synchroniser time
    task automatic pin(logic [15:0] p);
        @(posedge clk_sys);
        dma_req_pin <= p;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic pulse(dcc_eng_evt_t ev);
        @(posedge clk_sys);
        ctl <= ev;
        @(posedge clk_sys);
        ctl <= '0;
        @(negedge clk_sys);
    endtask
    function automatic logic [31:0] cw(logic h, logic l, logic [1:0] m, logic [2:0] f,
        logic [3:0] dd, logic [3:0] ss, logic en);
        return {13'h0, h, 1'b0, l, m, f, 1'b0, dd, 1'b0, ss, en};
    endfunction
    // {src, dst, owner} per flow code, code 7 in the top nibble
    function automatic logic [3:0] exp_xfer(logic [2:0] c);
        return 4'(32'heb7dc840 >> (4 * c));
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h826b41a0));
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(8'(i * 4));
            chk("reset read", d, 32'h0);
        end
        $display("reset test done");
        for (int f = 0; f < 8; f++) begin
            v = cw(1'b0, 1'b0, 2'($urandom), 3'(f), 4'($urandom), 4'($urandom), 1'b0);
            wr(DCC_OFS_CFG, v);
            chk("xfer", 32'(xfer), 32'(exp_xfer(3'(f))));
            rd(DCC_OFS_CFG);
            chk("cfg readback", d, v);
        end
        $display("flow decode test done");
        for (int i = 0; i < 3; i++) begin
            s = (i == 0) ? 4'h7 : 4'($urandom);
            go(cw(1'b0, 1'b0, 2'h0, 3'h2, 4'h0, s, 1'b1));
            pin(16'h1 << (s ^ 4'h1));
            chk("grant other line", 32'(src_req_grant), 32'h0);
            pin(16'h1 << s);
            chk("grant", 32'(src_req_grant), 32'h1);
            chk("dst memory", 32'(dst_req_level), 32'h0);
        end
        pin(16'hffff);
        go(cw(1'b0, 1'b0, 2'h0, 3'h0, s, s, 1'b1));
        chk("grant memory", 32'(src_req_grant), 32'h0);
        go(cw(1'b0, 1'b0, 2'h0, 3'h1, s, s, 1'b1));
        chk("dst level", 32'(dst_req_level), 32'h1);
        $display("request select test done");
        go(cw(1'b0, 1'b0, 2'h0, 3'h2, 4'h0, s, 1'b1));
        mode = 2'h2;
        repeat (40) @(negedge clk_sys);
        chk("full", 32'(fifo_full), 32'h1);
        chk("active", 32'(fifo_active), 32'h1);
        wr(DCC_OFS_CFG, cw(1'b1, 1'b0, 2'h0, 3'h2, 4'h0, s, 1'b1));
        mode = 2'h0;
        chk("halt grant", 32'(src_req_grant), 32'h0);
        for (int k = 0; k < 40 && (k == 0 || d[17] !== 1'b0); k++) begin
            rd(DCC_OFS_CFG);
        end
        chk("active bit", 32'(d[17]), 32'h0);
        chk("halt grant empty", 32'(src_req_grant), 32'h0);
        wr(DCC_OFS_CFG, cw(1'b0, 1'b0, 2'h0, 3'h2, 4'h0, s, 1'b1));
        chk("resume grant", 32'(src_req_grant), 32'h1);
        @(posedge clk_sys);
        ctl.bus_busy <= 1'b1;
        wr(DCC_OFS_CFG, cw(1'b0, 1'b0, 2'h0, 3'h2, 4'h0, s, 1'b0));
        chk("stop while busy", 32'(chan_enabled), 32'h1);
        @(posedge clk_sys);
        ctl.bus_busy <= 1'b0;
        rd(DCC_OFS_ENSTS);
        chk("status off", d, 32'h0);
        chk("flushed", 32'(fifo_active), 32'h0);
        $display("halt and stop test done");
        for (int k = 0; k < 2; k++) begin
            go(cw(1'b0, 1'(k), 2'h0, 3'h0, 4'h0, 4'h0, 1'b1));
            chk("lock", 32'(bus_lock), 32'(k));
            rd(DCC_OFS_ENSTS);
            chk("status on", d, 32'h1);
            pulse(k ? 6'h02 : 6'h04); // Error, or last item
            rd(DCC_OFS_CFG);
            chk("self disable", 32'(d[0]), 32'h0);
        end
        $display("lock and self disable test done");
        go(cw(1'b0, 1'b0, 2'h0, 3'h0, 4'h0, 4'h0, 1'b1));
        pulse(6'h03); // Terminal count and error
        chk("tc masked", 32'(tc_irq), 32'h0);
        chk("err masked", 32'(err_irq), 32'h0);
        rd(DCC_OFS_ISTS);
        chk("irq status", d, 32'h7);
        wr(DCC_OFS_CFG, cw(1'b0, 1'b0, 2'h3, 3'h0, 4'h0, 4'h0, 1'b0));
        chk("tc passed", 32'(tc_irq), 32'h1);
        chk("err passed", 32'(err_irq), 32'h1);
        chk("irq mask off", 32'(irq), 32'h0);
        wr(DCC_OFS_IMSK, 32'h3);
        chk("irq on", 32'(irq), 32'h1);
        wr(DCC_OFS_ISTS, 32'h7);
        chk("irq cleared", 32'(irq), 32'h0);
        chk("tc cleared", 32'(tc_irq), 32'h0);
        $display("interrupt test done");
        final_report();
    end
endmodule
